// file: pkg/enh_map.svh
// Register addresses, field positions and reset values of the enhanced read/write map.
`ifndef ENH_MAP_SVH
`define ENH_MAP_SVH

// ----------------------------------------------------------------
// Command/pointer fields
// ----------------------------------------------------------------
`define CMD_POINT_HIGH 3'h1
`define POINT_HIGH_OFFSET 4'h8

// ----------------------------------------------------------------
// Write addresses
// ----------------------------------------------------------------
`define WA_COMMAND 4'h0
`define WA_SHARED_VECTOR 4'h2
`define WA_RX_PARAM 4'h3
`define WA_MISC_MODE 4'h4
`define WA_TX_PARAM 4'h5
`define WA_SYNC_FLAG 4'h7
`define WA_SHARED_MASTER 4'h9
`define WA_MISC_TXRX 4'ha
`define WA_OPTIONS 4'hf

// ----------------------------------------------------------------
// Read addresses and status images
// ----------------------------------------------------------------
`define RA_FIFO_LOW 4'h6
`define RA_FIFO_HIGH 4'h7
`define RA_NINE 4'h9
`define RA_ELEVEN 4'hb
`define RA_FOURTEEN 4'he
`define RR_RX_DATA 4'h8
`define RR_MISC_STATUS 4'ha
`define RR_TC_HIGH 4'hd
`define RR_EXT_STATUS 4'hf

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OPT_ENH_BIT 0
`define OPT_FIFO_BIT 2
`define HID_EXT_READ_BIT 6
`define HID_WRITE_MASK 8'h7f
`define OPT_RESET 8'h00
`define HIDDEN_RESET 8'h00
`define SHARED_RESET 8'h00

`endif

// file: pkg/enh_pkg.sv
// Types shared by the enhanced register map decoder.
package enh_pkg;
	typedef enum logic [1:0] {SRC_STATUS, SRC_WREG, SRC_HIDDEN} src_e;
endpackage

// file: rtl/enhanced_register_map_decode.sv
// Pointer-addressed register map with enhancement options and extended read.
`timescale 1ns/1ns
`include "enh_map.svh"

module enhanced_register_map_decode
	import enh_pkg::*;
#(
	parameter int DW = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic data_sel,
	input wire logic chan_a,
	input wire logic [DW-1:0] wr_data,
	input wire logic [DW-1:0] rr_data,
	output logic [3:0] rr_index,
	output logic rr_chan_a,
	output logic [DW-1:0] rd_data,
	output logic rd_valid,
	output logic [DW-1:0] option_a,
	output logic [DW-1:0] option_b,
	output logic [DW-1:0] hidden_a,
	output logic [DW-1:0] hidden_b,
	output logic [DW-1:0] shared_vector,
	output logic [DW-1:0] shared_master
);
	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_ff, rst_n;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n <= rst_s1_ff;
		end
	end

	// ----------------------------------------------------------------
	// Read map decode
	// ----------------------------------------------------------------
	function automatic logic [5:0] read_map(input logic [3:0] p, input logic fifo,
		input logic ext);
		logic [5:0] r;
		r = {SRC_STATUS, p};
		case (p)
			4'h4, 4'h5: r = ext ? {SRC_WREG, p} : {SRC_STATUS, 2'b00, p[1:0]};
			`RA_FIFO_LOW, `RA_FIFO_HIGH:
				r = fifo ? {SRC_STATUS, p} : {SRC_STATUS, 2'b00, p[1:0]};
			`RA_NINE: r = ext ? {SRC_WREG, `WA_RX_PARAM} : {SRC_STATUS, `RR_TC_HIGH};
			`RA_ELEVEN: r = ext ? {SRC_WREG, `WA_MISC_TXRX} : {SRC_STATUS, `RR_EXT_STATUS};
			`RA_FOURTEEN: r = ext ? {SRC_HIDDEN, p} : {SRC_STATUS, `RR_MISC_STATUS};
			default: r = {SRC_STATUS, p};
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [3:0] ptr_ff, nxt_ptr;
	logic [DW-1:0] opt_a_ff, opt_b_ff, hid_a_ff, hid_b_ff, vec_ff, mst_ff;
	logic [DW-1:0] nxt_opt_a, nxt_opt_b, nxt_hid_a, nxt_hid_b, nxt_vec, nxt_mst;
	logic [DW-1:0] opt_sel, hid_sel;
	logic fifo_en, ext_en, ctl_rd, ctl_wr, mem_we;
	logic [5:0] map;

	assign opt_sel = chan_a ? opt_a_ff : opt_b_ff;
	assign hid_sel = chan_a ? hid_a_ff : hid_b_ff;
	assign fifo_en = opt_sel[`OPT_FIFO_BIT];
	// Extended read needs the enhancement enable as well as its own bit.
	assign ext_en = opt_sel[`OPT_ENH_BIT]
		& hid_sel[`HID_EXT_READ_BIT];
	assign ctl_rd = rd_req & ~data_sel;
	assign ctl_wr = wr_req & ~data_sel & ~rd_req;
	assign map = read_map(ptr_ff, fifo_en, ext_en);

	always_comb begin
		nxt_ptr = ptr_ff;
		nxt_opt_a = opt_a_ff;
		nxt_opt_b = opt_b_ff;
		nxt_hid_a = hid_a_ff;
		nxt_hid_b = hid_b_ff;
		nxt_vec = vec_ff;
		nxt_mst = mst_ff;
		mem_we = 1'b0;
		if (ctl_rd) begin
			nxt_ptr = 4'h0;
		end else if (ctl_wr) begin
			nxt_ptr = 4'h0;
			case (ptr_ff)
				`WA_COMMAND: begin
					nxt_ptr = {1'b0, wr_data[2:0]};
					if (wr_data[5:3] == `CMD_POINT_HIGH) begin
						nxt_ptr = `POINT_HIGH_OFFSET | {1'b0, wr_data[2:0]};
					end
				end
				`WA_SHARED_VECTOR: nxt_vec = wr_data;
				`WA_SHARED_MASTER: nxt_mst = wr_data;
				`WA_SYNC_FLAG: begin
					if (opt_sel[`OPT_ENH_BIT]) begin
						// Bit 7 is never stored, so it always reads back as zero.
						if (chan_a) begin
							nxt_hid_a = wr_data & `HID_WRITE_MASK;
						end else begin
							nxt_hid_b = wr_data & `HID_WRITE_MASK;
						end
					end else begin
						mem_we = 1'b1;
					end
				end
				`WA_OPTIONS: begin
					if (chan_a) begin
						nxt_opt_a = wr_data;
					end else begin
						nxt_opt_b = wr_data;
					end
				end
				default: mem_we = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_ff <= 4'h0;
			opt_a_ff <= `OPT_RESET;
			opt_b_ff <= `OPT_RESET;
			hid_a_ff <= `HIDDEN_RESET;
			hid_b_ff <= `HIDDEN_RESET;
			vec_ff <= `SHARED_RESET;
			mst_ff <= `SHARED_RESET;
		end else begin
			ptr_ff <= nxt_ptr;
			opt_a_ff <= nxt_opt_a;
			opt_b_ff <= nxt_opt_b;
			hid_a_ff <= nxt_hid_a;
			hid_b_ff <= nxt_hid_b;
			vec_ff <= nxt_vec;
			mst_ff <= nxt_mst;
		end
	end

	// ----------------------------------------------------------------
	// Read pipeline
	// ----------------------------------------------------------------
	// Stage one holds the decoded source; the status image is fetched from
	// outside during that cycle, so the answer costs two cycles but every
	// data output stays a flip-flop.
	logic [1:0] src_ff, nxt_src;
	logic [3:0] idx_ff, nxt_idx;
	logic chan_ff, nxt_chan, pend_ff, nxt_pend, valid_ff, nxt_valid;
	logic [DW-1:0] snap_ff, nxt_snap, data_ff, nxt_data, mem_rdata;

	always_comb begin
		nxt_src = src_ff;
		nxt_idx = idx_ff;
		nxt_chan = chan_ff;
		nxt_snap = snap_ff;
		nxt_pend = rd_req;
		nxt_valid = pend_ff;
		nxt_data = data_ff;
		if (rd_req) begin
			nxt_chan = chan_a;
			nxt_snap = hid_sel;
			if (data_sel) begin
				nxt_src = SRC_STATUS;
				nxt_idx = `RR_RX_DATA;
			end else begin
				nxt_src = map[5:4];
				nxt_idx = map[3:0];
			end
		end
		if (pend_ff) begin
			case (src_e'(src_ff))
				SRC_WREG: nxt_data = mem_rdata;
				SRC_HIDDEN: nxt_data = snap_ff;
				default: nxt_data = rr_data;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			src_ff <= SRC_STATUS;
			idx_ff <= 4'h0;
			chan_ff <= 1'b0;
			snap_ff <= '0;
			pend_ff <= 1'b0;
			valid_ff <= 1'b0;
			data_ff <= '0;
		end else begin
			src_ff <= nxt_src;
			idx_ff <= nxt_idx;
			chan_ff <= nxt_chan;
			snap_ff <= nxt_snap;
			pend_ff <= nxt_pend;
			valid_ff <= nxt_valid;
			data_ff <= nxt_data;
		end
	end

	wreg_mem #(.DW(DW), .AW(5)) u_wreg (
		.mclk(mclk),
		.rst_n(rst_n),
		.we(mem_we),
		.waddr({chan_a, ptr_ff}),
		.wdata(wr_data),
		.raddr(data_sel ? {chan_a, ptr_ff} : {chan_a, map[3:0]}),
		.rdata(mem_rdata)
	);

	assign rr_index = idx_ff;
	assign rr_chan_a = chan_ff;
	assign rd_data = data_ff;
	assign rd_valid = valid_ff;
	assign option_a = opt_a_ff;
	assign option_b = opt_b_ff;
	assign hidden_a = hid_a_ff;
	assign hidden_b = hid_b_ff;
	assign shared_vector = vec_ff;
	assign shared_master = mst_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_flag_redirect: assert property (ctl_wr && ptr_ff == `WA_SYNC_FLAG && opt_sel[0]
		|=> (($past(chan_a) ? hid_a_ff : hid_b_ff) == {1'b0, $past(wr_data[6:0])}))
		else $error("hidden register not written by redirected flag write");
	a_flag_plain: assert property (ctl_wr && ptr_ff == `WA_SYNC_FLAG && !opt_sel[0]
		|=> $stable(hid_a_ff) && $stable(hid_b_ff))
		else $error("hidden register changed without enhancement enable");
	a_ext_nine: assert property (ctl_rd && ptr_ff == 4'h9 && ext_en
		|=> src_ff == SRC_WREG && idx_ff == 4'h3)
		else $error("address 9 did not map to receive parameter register");
	a_ext_eleven: assert property (ctl_rd && ptr_ff == 4'hb && ext_en
		|=> src_ff == SRC_WREG && idx_ff == 4'ha)
		else $error("address 11 did not map to txrx control register");
	a_hidden_read: assert property (ctl_rd && ptr_ff == 4'he && ext_en
		|-> ##2 rd_valid && rd_data == $past(hid_sel, 2))
		else $error("hidden register not returned at address 14");
	a_plain_images: assert property (ctl_rd && ptr_ff == 4'he && !ext_en
		|=> src_ff == SRC_STATUS && idx_ff == 4'ha)
		else $error("address 14 image wrong without extended read");
	a_ext_four: assert property (ctl_rd && ptr_ff == 4'h4 && ext_en
		|=> src_ff == SRC_WREG && idx_ff == 4'h4)
		else $error("pointer 4 did not return misc mode register");
	a_fifo_map: assert property (ctl_rd && ptr_ff == 4'h6
		|=> src_ff == SRC_STATUS && idx_ff == ($past(fifo_en) ? 4'h6 : 4'h2))
		else $error("pointer 6 mapped wrongly");
	a_fifo_only: assert property (ctl_rd && ptr_ff == 4'h5 && !opt_sel[0]
		|=> src_ff == SRC_STATUS && idx_ff == 4'h1)
		else $error("extended read leaked without enhancement enable");
	a_bit7_zero: assert property (!hid_a_ff[7] && !hid_b_ff[7])
		else $error("hidden register bit 7 set");
	a_ptr_clear: assert property ((ctl_rd || ctl_wr) && ptr_ff != 4'h0
		|=> ptr_ff == 4'h0)
		else $error("pointer not cleared after control access");
	a_point_high: assert property (ctl_wr && ptr_ff == 4'h0 && wr_data[5:3] == 3'h1
		|=> ptr_ff == {1'b1, $past(wr_data[2:0])})
		else $error("point high did not add eight");
	a_chan_access: assert property (rd_req |=> rr_chan_a == $past(chan_a))
		else $error("channel not taken at access");
	a_shared_write: assert property (ctl_wr && ptr_ff == 4'h2
		|=> vec_ff == $past(wr_data))
		else $error("shared vector write lost");
	a_read_answer: assert property (rd_req |-> ##2 rd_valid)
		else $error("read answer missing");

	c_redirect: cover property (ctl_wr && ptr_ff == `WA_SYNC_FLAG && opt_sel[0]);
	c_hidden_read: cover property (ctl_rd && ptr_ff == 4'he && ext_en);
	c_fifo_read: cover property (ctl_rd && ptr_ff == 4'h7 && fifo_en);
	c_point_high: cover property (ctl_wr && ptr_ff == 4'h0 && wr_data[5:3] == 3'h1);
endmodule // enhanced_register_map_decode

// file: rtl/wreg_mem.sv
// Small write-register store with a registered read port.
`timescale 1ns/1ns
module wreg_mem #(
	parameter int DW = 8,
	parameter int AW = 5
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_ff;
	logic [DW-1:0] nxt_rdata;

	// The array has no reset; software initialises every register it uses.
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_comb begin
		nxt_rdata = mem[raddr];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign rdata = rdata_ff;
endmodule // wreg_mem

// file: sim/host_status_model.sv
// Model of the status images that surround the register map decoder.
`timescale 1ns/1ns
module host_status_model (
	input wire logic [3:0] rr_index,
	input wire logic rr_chan_a,
	output logic [7:0] rr_data
);
	// Each image carries its channel and index, so a wrong selection shows in the value.
	assign rr_data = {rr_chan_a, 3'h5, rr_index};
endmodule // host_status_model

// file: sim/test_enhanced_register_map_decode.sv
// Self-checking testbench of the enhanced register map decoder.
`timescale 1ns/1ns
module test_enhanced_register_map_decode;
	logic mclk, nrst, rd_req, wr_req, data_sel, chan_a, rr_chan_a, rd_valid;
	logic [7:0] wr_data, rr_data, rd_data, option_a, option_b, hidden_a, hidden_b;
	logic [7:0] shared_vector, shared_master;
	logic [3:0] rr_index;
	int error_cnt;
	int compares;

	enhanced_register_map_decode i_dut (.mclk(mclk), .nrst(nrst), .rd_req(rd_req),
		.wr_req(wr_req), .data_sel(data_sel), .chan_a(chan_a), .wr_data(wr_data),
		.rr_data(rr_data), .rr_index(rr_index), .rr_chan_a(rr_chan_a), .rd_data(rd_data),
		.rd_valid(rd_valid), .option_a(option_a), .option_b(option_b), .hidden_a(hidden_a),
		.hidden_b(hidden_b), .shared_vector(shared_vector), .shared_master(shared_master));
	host_status_model i_host (.rr_index(rr_index), .rr_chan_a(rr_chan_a), .rr_data(rr_data));

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	function automatic logic [7:0] st(input logic ch, input logic [3:0] i);
		return {ch, 3'h5, i};
	endfunction

	task automatic results();
		$display("Compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Signals change once per clock cycle; the caller ends a sequence with an idle call.
	task automatic drive(input logic r, w, ds, ch, input logic [7:0] d);
		rd_req = r;
		wr_req = w;
		data_sel = ds;
		chan_a = ch;
		wr_data = d;
		@(posedge mclk);
		#2;
	endtask

	// The pointer is written on the other channel; the access itself picks the channel.
	task automatic point(input logic ch, input logic [3:0] a);
		drive(1'b0, 1'b1, 1'b0, ~ch, a[3] ? {5'h01, a[2:0]} : {5'h00, a[2:0]});
	endtask

	task automatic wreg(input logic ch, input logic [3:0] a, input logic [7:0] v);
		point(ch, a);
		drive(1'b0, 1'b1, 1'b0, ch, v);
		drive(1'b0, 1'b0, 1'b0, ch, 8'h00);
	endtask

	task automatic rnow(input logic ds, input logic ch, input logic [7:0] exp);
		drive(1'b1, 1'b0, ds, ch, 8'h00);
		drive(1'b0, 1'b0, 1'b0, ch, 8'h00);
		chk({7'h00, rd_valid}, 8'h01);
		chk(rd_data, exp);
	endtask

	task automatic rreg(input logic ch, input logic [3:0] a, input logic [7:0] exp);
		point(ch, a);
		rnow(1'b0, ch, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_plain();
		logic [3:0] a[8] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'he, 4'h2};
		logic [3:0] s[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'hf, 4'ha, 4'h2};
		chk(option_a | option_b | hidden_a | hidden_b, 8'h00);
		chk(shared_vector | shared_master, 8'h00);
		for (int i = 0; i < 16; i++) begin
			rreg(i[0], a[i/2], st(i[0], s[i/2]));
		end
	endtask

	task automatic t_ext();
		wreg(1'b1, 4'hf, 8'h01);
		chk(option_a, 8'h01);
		chk(option_b, 8'h00);
		wreg(1'b1, 4'h7, 8'hff);
		chk(hidden_a, 8'h7f);
		wreg(1'b1, 4'h3, 8'h33);
		wreg(1'b1, 4'h4, 8'h44);
		wreg(1'b1, 4'h5, 8'h55);
		wreg(1'b1, 4'ha, 8'haa);
		rreg(1'b1, 4'h9, 8'h33);
		rreg(1'b1, 4'hb, 8'haa);
		rreg(1'b1, 4'he, 8'h7f);
		rreg(1'b1, 4'h4, 8'h44);
		rreg(1'b1, 4'h5, 8'h55);
		rreg(1'b1, 4'h6, st(1'b1, 4'h2));
		rreg(1'b0, 4'h9, st(1'b0, 4'hd));
		wreg(1'b1, 4'hf, 8'h05);
		rreg(1'b1, 4'h7, st(1'b1, 4'h7));
		rreg(1'b1, 4'h9, 8'h33);
		wreg(1'b1, 4'h7, 8'h00);
		chk(hidden_a, 8'h00);
		rreg(1'b1, 4'he, st(1'b1, 4'ha));
		rreg(1'b1, 4'h4, st(1'b1, 4'h0));
	endtask

	task automatic t_fifo();
		wreg(1'b0, 4'hf, 8'h01);
		wreg(1'b0, 4'h7, 8'hc0);
		chk(hidden_b, 8'h40);
		wreg(1'b0, 4'hf, 8'h04);
		wreg(1'b0, 4'h7, 8'h3c);
		chk(hidden_b, 8'h40);
		rreg(1'b0, 4'h6, st(1'b0, 4'h6));
		rreg(1'b0, 4'h7, st(1'b0, 4'h7));
		rreg(1'b0, 4'h9, st(1'b0, 4'hd));
		rreg(1'b0, 4'h4, st(1'b0, 4'h0));
		rreg(1'b0, 4'he, st(1'b0, 4'ha));
	endtask

	task automatic t_shared();
		wreg(1'b0, 4'h2, 8'h5a);
		chk(shared_vector, 8'h5a);
		wreg(1'b1, 4'h9, 8'ha5);
		chk(shared_master, 8'ha5);
	endtask

	task automatic t_pointer();
		point(1'b1, 4'h5);
		rnow(1'b1, 1'b1, st(1'b1, 4'h8));
		rnow(1'b0, 1'b1, st(1'b1, 4'h1));
		rnow(1'b0, 1'b1, st(1'b1, 4'h0));
		rreg(1'b0, 4'hd, st(1'b0, 4'hd));
	endtask

	// ----------------------------------------------------------------
	// Clock, reset, sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		error_cnt = 0;
		compares = 0;
		nrst = 1'b0;
		rd_req = 1'b0;
		wr_req = 1'b0;
		data_sel = 1'b0;
		chan_a = 1'b0;
		wr_data = 8'h00;
		repeat (12) @(posedge mclk);
		#2;
		nrst = 1'b1;
		repeat (3) @(posedge mclk);
		#2;
		t_plain();
		t_ext();
		t_fifo();
		t_shared();
		t_pointer();
		results();
	end

	// The sequence needs well under a thousand cycles; this limit only cuts a hang.
	initial begin
		#(40 * 5000);
		error_cnt++;
		results();
	end
endmodule // test_enhanced_register_map_decode
